// >>> core/i2ccfg_cmd_exec.sv
// Purpose: system command acceptance, decode and busy tracking
// Assumes: proc_done pulses when an external update finishes
// Notes: a command is accepted the cycle after its write
`timescale 1ns/1ps
`default_nettype none
`include "i2ccfg_params.svh"
module i2ccfg_cmd_exec (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_we,
  input wire logic [7:0] cmd_wd,
  input wire logic proc_done,
  output logic [7:0] cmd_pend,
  output logic busy,
  output i2ccfg_pkg::i2ccfg_cmd_t act
);
  import i2ccfg_pkg::*;
  localparam int ACC_MAX = `I2CCFG_ACCEPT_CYC;
  logic [7:0] pend_r;
  logic busy_r, self_r;
  logic accepted, runnable;
  i2ccfg_cmd_t act_r, act_nxt;

  assign accepted = pend_r != 8'h00;
  assign runnable = accepted & ~busy_r;
  assign cmd_pend = pend_r;
  assign busy = busy_r;
  assign act = act_r;

  // a new write wins over the clear of acceptance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pend_r <= 8'h00;
    else pend_r <= cmd_we ? cmd_wd : 8'h00;
  end

  always_comb begin
    act_nxt = '0;
    if (accepted) begin
      case (pend_r)
        `I2CCFG_CMD_STANDBY: act_nxt.standby = 1'b1;
        `I2CCFG_CMD_ACTIVE: act_nxt.active = 1'b1;
        `I2CCFG_CMD_RST_SYS: act_nxt.rst_sys = 1'b1;
        `I2CCFG_CMD_RST_POR: act_nxt.rst_por = 1'b1;
        `I2CCFG_CMD_UPD_OFF: act_nxt.apply = runnable;
        `I2CCFG_CMD_UPD_OFF_F: begin
          act_nxt.apply = runnable;
          act_nxt.force_upd = runnable;
        end
        `I2CCFG_CMD_UPD_ON: begin
          act_nxt.apply = runnable;
          act_nxt.keep_on = runnable;
        end
        `I2CCFG_CMD_UPD_ON_F: begin
          act_nxt.apply = runnable;
          act_nxt.keep_on = runnable;
          act_nxt.force_upd = runnable;
        end
        `I2CCFG_CMD_RELOAD: act_nxt.refresh = runnable;
        default: act_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) act_r <= '0;
    else act_r <= act_nxt;
  end

  // busy spans processing; refresh finishes by itself in one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      self_r <= 1'b0;
    end else begin
      self_r <= act_nxt.refresh;
      if (act_nxt.apply | act_nxt.refresh) busy_r <= 1'b1;
      else if (busy_r & (proc_done | self_r)) busy_r <= 1'b0;
    end
  end

  a_cmd_clears: assert property (@(posedge clk) disable iff (rst)
    (accepted && !cmd_we) |=> pend_r == 8'h00)
    else $error("command not cleared after acceptance");
  a_accept_bound: assert property (@(posedge clk) disable iff (rst)
    $rose(accepted) |-> ##[1:ACC_MAX] (!accepted || $changed(pend_r)))
    else $error("command not accepted in time");
  a_busy_ignores: assert property (@(posedge clk) disable iff (rst)
    (busy_r && !proc_done && !self_r) |=> !act_r.apply && !act_r.refresh)
    else $error("update started while busy");
  a_apply_busy: assert property (@(posedge clk) disable iff (rst)
    (act_r.apply || act_r.refresh) |-> busy_r && !$past(busy_r))
    else $error("busy not raised with processing");
endmodule // i2ccfg_cmd_exec
`default_nettype wire

// >>> core/i2ccfg_line_edge.sv
// Purpose: registers scl/sda and flags edges, start and stop
// Assumes: pins synchronous to clk
// Notes: one cycle of edge latency
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_line_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output i2ccfg_pkg::i2ccfg_line_t line
);
  import i2ccfg_pkg::*;
  logic scl_a_r, scl_b_r, sda_a_r, sda_b_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_a_r <= 1'b1;
      scl_b_r <= 1'b1;
      sda_a_r <= 1'b1;
      sda_b_r <= 1'b1;
    end else begin
      scl_a_r <= scl_i;
      scl_b_r <= scl_a_r;
      sda_a_r <= sda_i;
      sda_b_r <= sda_a_r;
    end
  end

  always_comb begin
    line.scl = scl_a_r;
    line.sda = sda_a_r;
    line.rise = scl_a_r & ~scl_b_r;
    line.fall = ~scl_a_r & scl_b_r;
    line.start = scl_a_r & scl_b_r & ~sda_a_r & sda_b_r;
    line.stop = scl_a_r & scl_b_r & sda_a_r & ~sda_b_r;
  end
endmodule // i2ccfg_line_edge
`default_nettype wire

// >>> core/i2ccfg_params.svh
// Purpose: offsets, field positions, codes and timing for the i2c config port
// Assumes: 125 MHz core clock
// Notes: register offsets are local choices of this block
`ifndef I2CCFG_PARAMS_SVH
`define I2CCFG_PARAMS_SVH

`define I2CCFG_REG_FREQ0 8'h10
`define I2CCFG_REG_FREQ1 8'h11
`define I2CCFG_REG_FREQ2 8'h12
`define I2CCFG_REG_FREQ3 8'h13
`define I2CCFG_REG_CMD 8'h14
`define I2CCFG_REG_MODE 8'h15
`define I2CCFG_REG_STAT 8'h16
`define I2CCFG_REG_INCDIS 8'h17
`define I2CCFG_REG_ODIV 8'h18
`define I2CCFG_PTR_TOP 8'hff

`define I2CCFG_STAT_BUSY 7
`define I2CCFG_STAT_ACTIVE 1
`define I2CCFG_STAT_READY 0

`define I2CCFG_CMD_NOP 8'h00
`define I2CCFG_CMD_STANDBY 8'h01
`define I2CCFG_CMD_ACTIVE 8'h02
`define I2CCFG_CMD_NOP3 8'h03
`define I2CCFG_CMD_RST_SYS 8'h04
`define I2CCFG_CMD_RST_POR 8'h05
`define I2CCFG_CMD_UPD_OFF 8'h08
`define I2CCFG_CMD_UPD_OFF_F 8'h09
`define I2CCFG_CMD_UPD_ON 8'h0a
`define I2CCFG_CMD_UPD_ON_F 8'h0b
`define I2CCFG_CMD_RELOAD 8'h0c

`define I2CCFG_OPT_STANDBY 2'h0
`define I2CCFG_OPT_ACT_OFF 2'h1
`define I2CCFG_OPT_ACT_ON 2'h2

`define I2CCFG_CLK_NS 8
`define I2CCFG_ACCEPT_NS 5000
`define I2CCFG_ACCEPT_CYC (`I2CCFG_ACCEPT_NS / `I2CCFG_CLK_NS)

`endif

// >>> core/i2ccfg_pkg.sv
// Purpose: shared types of the i2c config port
// Assumes: nothing
// Notes: constants live in i2ccfg_params.svh
package i2ccfg_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_PTR, PH_WR, PH_RD} i2ccfg_phase_t;
  typedef enum logic {DS_STANDBY, DS_ACTIVE} i2ccfg_dev_t;
  typedef struct packed {
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } i2ccfg_line_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } i2ccfg_wr_t;
  typedef struct packed {
    logic standby;
    logic active;
    logic rst_sys;
    logic rst_por;
    logic apply;
    logic refresh;
    logic force_upd;
    logic keep_on;
  } i2ccfg_cmd_t;
endpackage

// >>> core/i2ccfg_port.sv
// Purpose: i2c slave register port and command handling of the oscillator
// Assumes: scl/sda synchronous to clk; sda is open drain
// Notes: frequency and mode go live only on an update command or a power-on reset command
`timescale 1ns/1ps
`default_nettype none
`include "i2ccfg_params.svh"
module i2ccfg_port #(
  parameter logic [6:0] SLAVE_ADDR = 7'h55,
  parameter logic [31:0] DEF_FREQ = 32'h4c8583b0,
  parameter logic [7:0] DEF_MODE = 8'h01
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] pwr_opt,
  input wire logic update_done,
  output logic [31:0] freq_inuse,
  output logic [7:0] mode_inuse,
  output logic update_req,
  output logic update_force,
  output logic dev_active,
  output logic output_on,
  output logic restart_sys,
  output logic restart_por,
  output logic busy
);
  import i2ccfg_pkg::*;

  i2ccfg_line_t ln;
  i2ccfg_phase_t phase_r;
  i2ccfg_dev_t st_r;
  i2ccfg_wr_t wr_r;
  i2ccfg_cmd_t cmd;
  logic [3:0] bitcnt_r;
  logic [7:0] sh_r, tx_r, ptr_r, rd_data, cmd_pend;
  logic [31:0] freq_r, freq_use_r;
  logic [7:0] mode_r, mode_use_r;
  logic sda_oe_r, incdis_r, odiv_r, init_r, hold_off_r;
  logic upd_req_r, upd_force_r, out_on_r;

  function automatic logic [7:0] ptr_next(input logic [7:0] p,
                                          input logic dis);
    ptr_next = (dis || p == `I2CCFG_PTR_TOP) ? p : p + 8'h01;
  endfunction

  i2ccfg_line_edge u_edge (
    .clk(clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line(ln)
  );

  i2ccfg_cmd_exec u_exec (
    .clk(clk),
    .rst(rst),
    .cmd_we(wr_r.we && wr_r.addr == `I2CCFG_REG_CMD),
    .cmd_wd(wr_r.data),
    .proc_done(update_done),
    .cmd_pend(cmd_pend),
    .busy(busy),
    .act(cmd)
  );

  // sda only pulled low; scl is never driven
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;

  // serial engine: address, pointer, write and read bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= PH_IDLE;
      bitcnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      sda_oe_r <= 1'b0;
      wr_r <= '0;
    end else begin
      wr_r.we <= 1'b0;
      if (ln.start) begin
        phase_r <= PH_ADDR;
        bitcnt_r <= 4'hf; // the start's own scl fall wraps this to 0
        sda_oe_r <= 1'b0;
      end else if (ln.stop) begin
        phase_r <= PH_IDLE;
        sda_oe_r <= 1'b0;
      end else if (phase_r != PH_IDLE) begin
        if (ln.rise && bitcnt_r < 4'h8) begin
          sh_r <= {sh_r[6:0], ln.sda};
        end
        if (ln.rise && bitcnt_r == 4'h8 && phase_r == PH_RD && ln.sda) begin
          phase_r <= PH_IDLE;
        end
        if (ln.fall) begin
          if (bitcnt_r == 4'h7) begin
            bitcnt_r <= 4'h8;
            case (phase_r)
              PH_ADDR: begin
                if (sh_r[7:1] == SLAVE_ADDR) begin
                  sda_oe_r <= 1'b1;
                  phase_r <= sh_r[0] ? PH_RD : PH_PTR;
                end else begin
                  phase_r <= PH_IDLE;
                end
              end
              PH_PTR: begin
                sda_oe_r <= 1'b1;
                ptr_r <= sh_r;
                phase_r <= PH_WR;
              end
              PH_WR: begin
                sda_oe_r <= 1'b1;
                wr_r <= '{1'b1, ptr_r, sh_r};
                ptr_r <= ptr_next(ptr_r, incdis_r);
              end
              default: sda_oe_r <= 1'b0;
            endcase
          end else if (bitcnt_r == 4'h8) begin
            bitcnt_r <= 4'h0;
            if (phase_r == PH_RD) begin
              tx_r <= {rd_data[6:0], 1'b0};
              sda_oe_r <= ~rd_data[7];
              ptr_r <= ptr_next(ptr_r, incdis_r);
            end else begin
              sda_oe_r <= 1'b0;
            end
          end else begin
            bitcnt_r <= bitcnt_r + 4'h1;
            if (phase_r == PH_RD) begin
              sda_oe_r <= ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b0};
            end
          end
        end
      end
    end
  end

  // read mux; unmapped locations read zero
  always_comb begin
    case (ptr_r)
      `I2CCFG_REG_FREQ0: rd_data = freq_r[31:24];
      `I2CCFG_REG_FREQ1: rd_data = freq_r[23:16];
      `I2CCFG_REG_FREQ2: rd_data = freq_r[15:8];
      `I2CCFG_REG_FREQ3: rd_data = freq_r[7:0];
      `I2CCFG_REG_CMD: rd_data = cmd_pend;
      `I2CCFG_REG_MODE: rd_data = mode_r;
      `I2CCFG_REG_STAT: begin
        rd_data = 8'h00;
        rd_data[`I2CCFG_STAT_BUSY] = busy;
        rd_data[`I2CCFG_STAT_ACTIVE] = init_r && st_r == DS_ACTIVE;
        rd_data[`I2CCFG_STAT_READY] = init_r && st_r == DS_STANDBY;
      end
      `I2CCFG_REG_INCDIS: rd_data = {7'h00, incdis_r};
      `I2CCFG_REG_ODIV: rd_data = {7'h00, odiv_r};
      default: rd_data = 8'h00;
    endcase
  end

  // stored frequency, mode and pointer control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_r <= DEF_FREQ;
      mode_r <= DEF_MODE;
      incdis_r <= 1'b0;
    end else if (cmd.rst_por) begin
      freq_r <= DEF_FREQ;
      mode_r <= DEF_MODE;
      incdis_r <= 1'b0;
    end else begin
      if (cmd.refresh) begin
        freq_r <= freq_use_r;
        mode_r <= mode_use_r;
      end
      if (wr_r.we) begin
        case (wr_r.addr)
          `I2CCFG_REG_FREQ0: freq_r[31:24] <= wr_r.data;
          `I2CCFG_REG_FREQ1: freq_r[23:16] <= wr_r.data;
          `I2CCFG_REG_FREQ2: freq_r[15:8] <= wr_r.data;
          `I2CCFG_REG_FREQ3: freq_r[7:0] <= wr_r.data;
          `I2CCFG_REG_MODE: mode_r <= wr_r.data;
          `I2CCFG_REG_INCDIS: incdis_r <= wr_r.data[0];
          default: incdis_r <= incdis_r;
        endcase
      end
    end
  end

  // values in use change only on an update command or a power-on reset command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freq_use_r <= DEF_FREQ;
      mode_use_r <= DEF_MODE;
      upd_req_r <= 1'b0;
      upd_force_r <= 1'b0;
    end else begin
      upd_req_r <= cmd.apply;
      upd_force_r <= cmd.apply & cmd.force_upd;
      if (cmd.rst_por) begin
        freq_use_r <= DEF_FREQ;
        mode_use_r <= DEF_MODE;
      end else if (cmd.apply) begin
        freq_use_r <= freq_r;
        mode_use_r <= mode_r;
      end
    end
  end

  // power state, strap capture and output enable control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_r <= 1'b0;
      st_r <= DS_STANDBY;
      odiv_r <= 1'b0;
    end else if (!init_r) begin
      init_r <= 1'b1;
      st_r <= (pwr_opt == `I2CCFG_OPT_STANDBY) ? DS_STANDBY : DS_ACTIVE;
      odiv_r <= pwr_opt == `I2CCFG_OPT_ACT_ON;
    end else if (cmd.rst_sys || cmd.rst_por) begin
      init_r <= 1'b0;
    end else begin
      if (cmd.standby) st_r <= DS_STANDBY;
      else if (cmd.active) st_r <= DS_ACTIVE;
      if (wr_r.we && wr_r.addr == `I2CCFG_REG_ODIV) begin
        odiv_r <= wr_r.data[0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_off_r <= 1'b0;
      out_on_r <= 1'b0;
    end else begin
      if (cmd.apply) hold_off_r <= ~cmd.keep_on;
      else if (!busy) hold_off_r <= 1'b0;
      out_on_r <= init_r && st_r == DS_ACTIVE && odiv_r &&
                  !(hold_off_r && busy);
    end
  end

  assign freq_inuse = freq_use_r;
  assign mode_inuse = mode_use_r;
  assign update_req = upd_req_r;
  assign update_force = upd_force_r;
  assign dev_active = init_r && st_r == DS_ACTIVE;
  assign output_on = out_on_r;
  assign restart_sys = cmd.rst_sys;
  assign restart_por = cmd.rst_por;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_byte_end;
    ln.fall && bitcnt_r == 4'h7 && !ln.start && !ln.stop;
  endsequence
  sequence s_addr_hit;
    phase_r == PH_ADDR && sh_r[7:1] == SLAVE_ADDR;
  endsequence

  a_addr_ack: assert property ((s_addr_hit and s_byte_end) |=>
      sda_oe_r)
    else $error("matching address not acknowledged");
  a_addr_miss: assert property ((phase_r == PH_ADDR &&
      sh_r[7:1] != SLAVE_ADDR and s_byte_end) |=>
      !sda_oe_r && phase_r == PH_IDLE)
    else $error("foreign address answered");
  a_ptr_frozen: assert property (wr_r.we && $past(incdis_r) |->
      ptr_r == wr_r.addr)
    else $error("pointer moved while frozen");
  a_ptr_step: assert property (wr_r.we && !$past(incdis_r) |->
      ptr_r == ptr_next(wr_r.addr, 1'b0))
    else $error("pointer did not advance");
  a_msb_first: assert property (phase_r == PH_RD && ln.fall &&
      bitcnt_r == 4'h8 && !ln.stop && !ln.start |=>
      sda_oe_r == ~$past(rd_data[7]))
    else $error("read byte not msb first");
  a_apply_live: assert property (upd_req_r |->
      freq_use_r == $past(freq_r) && mode_use_r == $past(mode_r))
    else $error("update did not take stored values");
  a_freq_held: assert property (!cmd.apply && !cmd.rst_por |=>
      $stable(freq_use_r) && $stable(mode_use_r))
    else $error("values in use changed without update");
  a_standby_cmd: assert property (cmd.standby && init_r &&
      !cmd.rst_sys |=> !dev_active ##1 !output_on)
    else $error("standby command ignored");
  a_out_held_off: assert property (hold_off_r && busy |=>
      !output_on)
    else $error("output ran during off update");
endmodule // i2ccfg_port
`default_nettype wire

// >>> tb/i2ccfg_master.sv
// Purpose: i2c bus master model driving the config port
// Assumes: scl and sda change a little after a clk edge
// Notes: open drain; sda_m 1 releases the line
`timescale 1ns/1ps
`default_nettype none
module i2ccfg_master (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl_o,
  output logic sda_m
);
  localparam int QTR = 4;
  initial begin
    scl_o = 1'b1;
    sda_m = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start_cond();
    sda_m = 1'b1;
    wt(QTR);
    scl_o = 1'b1;
    wt(QTR);
    sda_m = 1'b0;
    wt(QTR);
    scl_o = 1'b0;
    wt(QTR);
  endtask
  task automatic stop_cond();
    sda_m = 1'b0;
    wt(QTR);
    scl_o = 1'b1;
    wt(QTR);
    sda_m = 1'b1;
    wt(QTR);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    wt(QTR);
    scl_o = 1'b1;
    wt(QTR);
    r = sda_line;
    wt(QTR);
    scl_o = 1'b0;
    wt(QTR);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  // pointer byte then data bytes, first byte in d[63:56]
  task automatic write_regs(input logic [6:0] a, input logic [7:0] ptr,
                            input logic [63:0] d, input int n,
                            output logic ok);
    logic k;
    start_cond();
    put_byte({a, 1'b0}, ok);
    put_byte(ptr, k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      put_byte(d[63-8*i -: 8], k);
      ok &= k;
    end
    stop_cond();
  endtask
  task automatic read_regs(input logic [6:0] a, input logic [7:0] ptr,
                           input int n, output logic [63:0] q,
                           output logic ok);
    logic k;
    logic [7:0] b;
    q = 64'h0;
    write_regs(a, ptr, 64'h0, 0, ok);
    start_cond();
    put_byte({a, 1'b1}, k);
    ok &= k;
    for (int i = 0; i < n; i++) begin
      get_byte(i == n - 1, b);
      q[63-8*i -: 8] = b;
    end
    stop_cond();
  endtask
endmodule // i2ccfg_master
`default_nettype wire

// >>> tb/i2ccfg_port_tb.sv
// Purpose: self-checking bench of the i2c config port
// Assumes: strap selects active with output off
// Notes: the bench plays the frequency engine via update_done
`timescale 1ns/1ps
`default_nettype none
`include "i2ccfg_params.svh"
module i2ccfg_port_tb;
  localparam logic [6:0] SLV = 7'h55;
  localparam logic [31:0] DEF_FREQ = 32'h4c8583b0;
  localparam logic [31:0] NEW_FREQ = 32'h4b3ebc20;
  logic clk, rst, scl, sda_m, sda_line, sda_o, sda_oe, update_done;
  logic [1:0] pwr_opt;
  logic [31:0] freq_inuse;
  logic [7:0] mode_inuse;
  logic update_req, update_force, dev_active, output_on;
  logic restart_sys, restart_por, busy;
  int failures, comparisons, n_upd, n_force, n_sys, n_por;
  assign sda_line = sda_m & ~(sda_oe & ~sda_o);
  i2ccfg_port #(.SLAVE_ADDR(SLV), .DEF_FREQ(DEF_FREQ)) uut (.clk(clk),
    .rst(rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .pwr_opt(pwr_opt), .update_done(update_done),
    .freq_inuse(freq_inuse), .mode_inuse(mode_inuse),
    .update_req(update_req), .update_force(update_force),
    .dev_active(dev_active), .output_on(output_on),
    .restart_sys(restart_sys), .restart_por(restart_por), .busy(busy));
  i2ccfg_master m0 (.clk(clk), .sda_line(sda_line), .scl_o(scl),
    .sda_m(sda_m));
  always @(posedge clk) begin
    if (update_req === 1'b1) n_upd <= n_upd + 1;
    if (update_force === 1'b1) n_force <= n_force + 1;
    if (restart_sys === 1'b1) n_sys <= n_sys + 1;
    if (restart_por === 1'b1) n_por <= n_por + 1;
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [63:0] d,
                    input int n);
    logic ok;
    m0.write_regs(SLV, ptr, d, n, ok);
    chk("write ack", 1, ok);
    m0.wt(12);
  endtask
  task automatic rd(input logic [7:0] ptr, input int n,
                    output logic [63:0] q);
    logic ok;
    m0.read_regs(SLV, ptr, n, q, ok);
    chk("read ack", 1, ok);
  endtask
  task automatic done_pulse();
    update_done = 1'b1;
    m0.wt(1);
    update_done = 1'b0;
    m0.wt(4);
  endtask
  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_power_up();
    logic [63:0] q;
    chk("active after reset", 1, dev_active);
    chk("output held off", 0, output_on);
    chk("freq default", DEF_FREQ, freq_inuse);
    chk("mode default", 8'h01, mode_inuse);
    rd(`I2CCFG_REG_STAT, 1, q);
    chk("status active", 8'h02, q[63:56]);
    rd(8'h20, 1, q);
    chk("unmapped reads zero", 8'h00, q[63:56]);
    $display("test power_up done");
  endtask
  task automatic t_slave_addr();
    logic ok;
    m0.write_regs(7'h54, `I2CCFG_REG_ODIV, 64'h01 << 56, 1, ok);
    chk("foreign address nack", 0, ok);
    m0.wt(12);
    chk("foreign write ignored", 0, output_on);
    $display("test slave_addr done");
  endtask
  task automatic t_output_enable();
    wr(`I2CCFG_REG_ODIV, 64'h01 << 56, 1);
    chk("output enabled", 1, output_on);
    $display("test output_enable done");
  endtask
  task automatic t_freq_apply();
    logic [63:0] q;
    wr(`I2CCFG_REG_FREQ0, {NEW_FREQ, 32'h0}, 4);
    chk("freq only stored", DEF_FREQ, freq_inuse);
    chk("no update yet", 0, n_upd);
    rd(`I2CCFG_REG_FREQ0, 4, q);
    chk("freq readback", NEW_FREQ, q[63:32]);
    wr(`I2CCFG_REG_CMD, {`I2CCFG_CMD_UPD_OFF, 56'h0}, 1);
    chk("update pulse", 1, n_upd);
    chk("not forced", 0, n_force);
    chk("freq live", NEW_FREQ, freq_inuse);
    chk("busy set", 1, busy);
    chk("output off in update", 0, output_on);
    rd(`I2CCFG_REG_CMD, 1, q);
    chk("command cleared", 8'h00, q[63:56]);
    done_pulse();
    chk("busy cleared", 0, busy);
    chk("output back on", 1, output_on);
    $display("test freq_apply done");
  endtask
  task automatic t_busy_ignore();
    wr(`I2CCFG_REG_CMD, {`I2CCFG_CMD_UPD_ON, 56'h0}, 1);
    chk("second update", 2, n_upd);
    chk("output kept on", 1, output_on);
    wr(`I2CCFG_REG_MODE, 64'h03 << 56, 1);
    wr(`I2CCFG_REG_CMD, {`I2CCFG_CMD_UPD_ON_F, 56'h0}, 1);
    chk("busy update ignored", 2, n_upd);
    chk("mode not applied", 8'h01, mode_inuse);
    done_pulse();
    wr(`I2CCFG_REG_CMD, {`I2CCFG_CMD_UPD_ON_F, 56'h0}, 1);
    chk("forced update", 3, n_upd);
    chk("force flag", 1, n_force);
    chk("mode live", 8'h03, mode_inuse);
    done_pulse();
    $display("test busy_ignore done");
  endtask
  task automatic t_reload();
    logic [63:0] q;
    wr(`I2CCFG_REG_FREQ0, 64'h11 << 56, 1);
    wr(`I2CCFG_REG_MODE, 64'h07 << 56, 1);
    wr(`I2CCFG_REG_CMD, {`I2CCFG_CMD_RELOAD, 56'h0}, 1);
    rd(`I2CCFG_REG_FREQ0, 6, q);
    chk("freq reloaded", NEW_FREQ, q[63:32]);
    chk("mode reloaded", 8'h03, q[23:16]);
    $display("test reload done");
  endtask
  task automatic t_autoinc();
    logic [63:0] q;
    wr(`I2CCFG_REG_INCDIS, 64'h01 << 56, 1);
    wr(`I2CCFG_REG_FREQ0, 64'haabb << 48, 2);
    rd(`I2CCFG_REG_FREQ0, 2, q);
    chk("frozen pointer", 16'hbbbb, q[63:48]);
    wr(`I2CCFG_REG_INCDIS, 64'h00 << 56, 1);
    rd(`I2CCFG_REG_FREQ0, 2, q);
    chk("autoinc restored", 16'hbb3e, q[63:48]);
    $display("test autoinc done");
  endtask
  task automatic t_commands();
    logic [7:0] code [6];
    logic [5:0] act;
    logic [63:0] q;
    code = '{`I2CCFG_CMD_STANDBY, `I2CCFG_CMD_NOP, `I2CCFG_CMD_NOP3,
      `I2CCFG_CMD_ACTIVE, `I2CCFG_CMD_RST_SYS, `I2CCFG_CMD_RST_POR};
    act = 6'b111000;
    for (int i = 0; i < 6; i++) begin
      wr(`I2CCFG_REG_CMD, {code[i], 56'h0}, 1);
      chk("device state", act[i], dev_active);
      chk("system restarts", i >= 4, n_sys);
      chk("power-on restarts", i == 5, n_por);
      rd(`I2CCFG_REG_CMD, 1, q);
      chk("command cleared", 8'h00, q[63:56]);
    end
    rd(`I2CCFG_REG_FREQ0, 4, q);
    chk("por default freq", DEF_FREQ, q[63:32]);
    $display("test commands done");
  endtask
  task automatic t_restart_straps();
    logic [63:0] q;
    rst = 1'b1;
    pwr_opt = 2'h0;
    m0.wt(4);
    rst = 1'b0;
    m0.wt(4);
    chk("standby strap", 0, dev_active);
    rd(`I2CCFG_REG_STAT, 1, q);
    chk("status ready", 8'h01, q[63:56]);
    wr(`I2CCFG_REG_MODE, 64'h05 << 56, 1);
    wr(`I2CCFG_REG_CMD, {`I2CCFG_CMD_ACTIVE, 56'h0}, 1);
    chk("active by command", 1, dev_active);
    rd(`I2CCFG_REG_MODE, 1, q);
    chk("standby write kept", 8'h05, q[63:56]);
    rst = 1'b1;
    pwr_opt = 2'h2;
    m0.wt(4);
    rst = 1'b0;
    m0.wt(4);
    chk("active on strap", 1, dev_active);
    chk("output on strap", 1, output_on);
    $display("test restart_straps done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end
  initial begin
    rst = 1'b1;
    pwr_opt = 2'h1;
    update_done = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    m0.wt(4);
    t_power_up();
    t_slave_addr();
    t_output_enable();
    t_freq_apply();
    t_busy_ignore();
    t_reload();
    t_autoinc();
    t_commands();
    t_restart_straps();
    complete_run();
  end
endmodule // i2ccfg_port_tb
`default_nettype wire
